// ===== rtl/icu_pkg.sv
// icu_pkg: register map, field layout, reset values and modes of the input capture unit
// assumes a 32-bit APB slave with word-aligned registers
package icu_pkg;

  localparam int unsigned ICU_CHANNELS = 4;
  localparam int unsigned ICU_DEPTH    = 4;
  localparam int unsigned ICU_TW       = 16;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ICU_CTRL0_OFS   = 12'h000;
  localparam logic [11:0] ICU_CTRL_STRIDE = 12'h004;
  localparam logic [11:0] ICU_DATA0_OFS   = 12'h010;
  localparam logic [11:0] ICU_STAT_OFS    = 12'h020;
  localparam logic [11:0] ICU_MASK_OFS    = 12'h024;
  localparam logic [11:0] ICU_FILL_OFS    = 12'h028;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned ICU_MODE_LSB  = 0;
  localparam int unsigned ICU_TSEL_BIT  = 4;
  localparam int unsigned ICU_THR_LSB   = 5;
  localparam int unsigned ICU_WAKE_BIT  = 7;
  localparam int unsigned ICU_DMA_BIT   = 8;
  localparam logic [31:0] ICU_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] ICU_MASK_RST  = 32'h0000_0000;

  // status layout: bits 3:0 threshold reached per channel, bits 7:4 overflow
  localparam int unsigned ICU_OVF_LSB = 4;

  typedef enum logic [2:0] {
    ICU_MODE_OFF  = 3'h0,
    ICU_MODE_FALL = 3'h1,
    ICU_MODE_RISE = 3'h2,
    ICU_MODE_BOTH = 3'h3,
    ICU_MODE_DIV4 = 3'h4,
    ICU_MODE_DIV16 = 3'h5
  } icu_mode_t;

  localparam logic [3:0] ICU_DIV4_LAST  = 4'h3;
  localparam logic [3:0] ICU_DIV16_LAST = 4'hF;

endpackage

// ===== rtl/icu_fifo_if.sv
// icu_fifo_if: write and read strobes between a capture channel and its buffer
// assumes all users run on pclk
`timescale 1ns/100ps
`default_nettype none
interface icu_fifo_if #(parameter int unsigned TW = 16, parameter int unsigned DEPTH = 4);
  logic                       push;
  logic [TW-1:0]              wdata;
  logic                       pop;
  logic [TW-1:0]              rdata;
  logic [$clog2(DEPTH+1)-1:0] count;
  logic                       full;
  logic                       empty;
  modport producer (output push, output wdata, output pop,
                    input rdata, input count, input full, input empty);
  modport buffer   (input push, input wdata, input pop,
                    output rdata, output count, output full, output empty);
endinterface
`default_nettype wire

// ===== rtl/icu_fifo.sv
// icu_fifo: small capture buffer, oldest word on rdata from a register
// a push while full is ignored here (the channel still gives it and flags overflow)
`timescale 1ns/100ps
`default_nettype none
module icu_fifo #(
  parameter int unsigned TW    = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  icu_fifo_if.buffer f
);
  import icu_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);

  logic [TW-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [TW-1:0] rdata_q;
  logic          do_pop;
  logic [AW-1:0] rd_next;

  assign do_pop  = f.pop && (cnt_q != '0);
  assign rd_next = do_pop ? AW'(rd_q + 1'b1) : rd_q;

  always_ff @(posedge pclk) begin
    if (ce && f.push && cnt_q != CW'(DEPTH)) begin
      mem_q[wr_q] <= f.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (f.push && cnt_q != CW'(DEPTH)) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      rd_q <= rd_next;
      cnt_q <= CW'(cnt_q + CW'(f.push && cnt_q != CW'(DEPTH)) - CW'(do_pop));
    end
  end

  // read data registered: shows the oldest word, or the word being written into empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else if (ce) begin
      if (cnt_q == CW'(do_pop) && f.push) begin
        rdata_q <= f.wdata;
      end else begin
        rdata_q <= mem_q[rd_next];
      end
    end
  end

  assign f.rdata = rdata_q;
  assign f.count = cnt_q;
  assign f.full  = (cnt_q == CW'(DEPTH));
  assign f.empty = (cnt_q == '0);
endmodule
`default_nettype wire

// ===== rtl/icu_channel.sv
// icu_channel: one capture channel: synchroniser, edge detect, prescaler, overflow
// assumes time bases are synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module icu_channel #(
  parameter int unsigned TW = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          pin,
  input  wire logic [2:0]    mode,
  input  wire logic          tsel,
  input  wire logic [TW-1:0] base_a,
  input  wire logic [TW-1:0] base_b,
  input  wire logic          ovf_clr,
  output logic               capture,
  output logic               pin_edge,
  output logic               ovf,
  icu_fifo_if.producer       f
);
  import icu_pkg::*;

  logic       s1_q;
  logic       s2_q;
  logic       s3_q;
  logic [3:0] pre_q;
  logic       ovf_q;
  logic       rise;
  logic       fall;
  logic       hit;
  logic [TW-1:0] stamp;

  // ----------------------------------------------------------------
  // synchroniser: s1 feeds only s2
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q && !s3_q;
  assign fall = !s2_q && s3_q;

  // prescaler counts rising edges only in the divided modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (ce) begin
      if (mode != ICU_MODE_DIV4 && mode != ICU_MODE_DIV16) begin
        pre_q <= '0;
      end else if (rise) begin
        pre_q <= hit ? 4'h0 : 4'(pre_q + 4'h1);
      end
    end
  end

  always_comb begin
    unique case (mode)
      ICU_MODE_FALL:  hit = fall;
      ICU_MODE_RISE:  hit = rise;
      ICU_MODE_BOTH:  hit = rise || fall;
      ICU_MODE_DIV4:  hit = rise && pre_q == ICU_DIV4_LAST;
      ICU_MODE_DIV16: hit = rise && pre_q == ICU_DIV16_LAST;
      default:        hit = 1'b0;
    endcase
  end

  assign stamp   = tsel ? base_b : base_a;
  assign f.push  = ce && hit;
  assign f.wdata = stamp;
  assign capture = hit;
  assign pin_edge = rise || fall;

  // overflow: set wins over clear; cleared when software reads the buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
    end else if (ce) begin
      if (hit && f.full) begin
        ovf_q <= 1'b1;
      end else if (ovf_clr) begin
        ovf_q <= 1'b0;
      end
    end
  end
  assign ovf = ovf_q;

  AST_OVF_SET: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && hit && f.full |=> ovf_q) else $error("overflow not flagged");
endmodule
`default_nettype wire

// ===== rtl/icu_top.sv
// icu_top: four-channel input capture unit with APB registers
// Operation
// - a qualifying pin event stores the selected 16-bit timer count
// - falling mode captures on every high-to-low pin transition
// - rising mode captures on every low-to-high pin transition
// - both-edges mode captures on every pin transition
// - divide-by-four mode captures on every fourth rising edge
// - divide-by-sixteen mode captures on every sixteenth rising edge
// - each channel picks time base a or b as its timestamp
// - four independent channels, each with pin, mode, base and buffer
// - each channel buffers captures in a four-deep FIFO
// - a capture can raise an interrupt request
// - interrupt asserts at a fill level of one to four entries
// - a capture event can wake the processor from sleep or idle
// - only channels zero and one may request DMA
// - pin events can serve as a plain external interrupt source
// assumes pclk 100 MHz, timers and pins synchronous to pclk, APB master
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module icu_top #(
  parameter int unsigned NCH = icu_pkg::ICU_CHANNELS,
  parameter int unsigned TW  = icu_pkg::ICU_TW
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic [NCH-1:0] capture_input_pin,
  input  wire logic [TW-1:0] time_base_a,
  input  wire logic [TW-1:0] time_base_b,
  input  wire logic          cpu_low_power,
  output logic               irq,
  output logic               wake_req,
  output logic [1:0]         dma_req,
  output logic [NCH-1:0]     ext_event
);
  import icu_pkg::*;

  localparam int unsigned CW = $clog2(ICU_DEPTH+1);

  logic [31:0]    ctrl_q [NCH];
  logic [2*NCH-1:0] stat_q;
  logic [2*NCH-1:0] mask_q;
  logic           pready_q;
  logic [31:0]    prdata_q;
  logic           pslverr_q;
  logic           irq_q;
  logic           wake_q;
  logic [1:0]     dma_q;
  logic [NCH-1:0] ext_q;

  logic           wr_en;
  logic           rd_en;
  logic [NCH-1:0] cap;
  logic [NCH-1:0] edg;
  logic [NCH-1:0] ovf;
  logic [NCH-1:0] pop;
  logic [NCH-1:0] thr_hit;
  logic [CW-1:0]  cnt [NCH];
  logic [TW-1:0]  rdat [NCH];
  logic [31:0]    rd_mux;
  logic           hit_map;

  // ----------------------------------------------------------------
  // APB access: access phase with one wait state, answer registered
  // ----------------------------------------------------------------
  // pready is asserted in the second access cycle, so the request completes one wait state after penable rises
  assign wr_en = clk_en && psel && penable && pwrite && !pready_q;
  assign rd_en = clk_en && psel && penable && !pwrite && !pready_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else if (clk_en) begin
      pready_q <= psel && penable && !pready_q;
    end
  end

  // ----------------------------------------------------------------
  // channels and buffers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      icu_fifo_if #(.TW(TW), .DEPTH(ICU_DEPTH)) fif ();
      logic [1:0] thr;

      icu_channel #(.TW(TW)) u_ch (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (clk_en),
        .pin      (capture_input_pin[g]),
        .mode     (ctrl_q[g][ICU_MODE_LSB +: 3]),
        .tsel     (ctrl_q[g][ICU_TSEL_BIT]),
        .base_a   (time_base_a),
        .base_b   (time_base_b),
        .ovf_clr  (pop[g]),
        .capture  (cap[g]),
        .pin_edge (edg[g]),
        .ovf      (ovf[g]),
        .f        (fif.producer)
      );

      icu_fifo #(.TW(TW), .DEPTH(ICU_DEPTH)) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (clk_en),
        .f       (fif.buffer)
      );

      assign fif.pop = pop[g];
      assign cnt[g]  = fif.count;
      assign rdat[g] = fif.rdata;
      assign thr     = ctrl_q[g][ICU_THR_LSB +: 2];
      // code n: status sets on a capture that leaves n+1 or more entries filled
      assign thr_hit[g] = cnt[g] >= CW'({1'b0, thr});
      assign pop[g] = rd_en && paddr == 12'(ICU_DATA0_OFS + 12'(g) * ICU_CTRL_STRIDE);
    end
  endgenerate

  // ----------------------------------------------------------------
  // control registers with byte strobes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_q[i] <= ICU_CTRL_RST;
      end
      mask_q <= ICU_MASK_RST[2*NCH-1:0];
    end else if (wr_en) begin
      for (int i = 0; i < NCH; i++) begin
        if (paddr == 12'(ICU_CTRL0_OFS + 12'(i) * ICU_CTRL_STRIDE)) begin
          for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
              ctrl_q[i][8*b +: 8] <= pwdata[8*b +: 8];
            end
          end
        end
      end
      if (paddr == ICU_MASK_OFS && pstrb[0]) begin
        mask_q <= pwdata[2*NCH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky status: threshold reached and overflow, write one to clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NCH; i++) begin
        // set wins over a clear in the same cycle
        if (thr_hit[i] && cap[i]) begin
          stat_q[i] <= 1'b1;
        end else if (wr_en && paddr == ICU_STAT_OFS && pstrb[0] && pwdata[i]) begin
          stat_q[i] <= 1'b0;
        end
        if (ovf[i]) begin
          stat_q[ICU_OVF_LSB+i] <= 1'b1;
        end else if (wr_en && paddr == ICU_STAT_OFS && pstrb[0]
                     && pwdata[ICU_OVF_LSB+i]) begin
          stat_q[ICU_OVF_LSB+i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs: interrupt, wake, dma and raw event strobes, all registered
  // ----------------------------------------------------------------
  // level interrupt, one cycle behind the status it reflects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // pin edges work as plain interrupt sources even with mode off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= '0;
    end else if (clk_en) begin
      ext_q <= edg;
    end
  end

  // wake is a one-cycle pulse: the power controller has to latch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else if (clk_en) begin
      wake_q <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        if (cpu_low_power && ctrl_q[i][ICU_WAKE_BIT] && (cap[i] || edg[i])) begin
          wake_q <= 1'b1;
        end
      end
    end
  end

  // the dma bit of channels two and up is stored but never honoured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_q <= '0;
    end else if (clk_en) begin
      // software keeps threshold at one entry for dma use
      for (int i = 0; i < 2; i++) begin
        dma_q[i] <= (i < NCH) && cap[i] && ctrl_q[i][ICU_DMA_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux  = 32'h0000_0000;
    hit_map = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (paddr == 12'(ICU_CTRL0_OFS + 12'(i) * ICU_CTRL_STRIDE)) begin
        rd_mux  = ctrl_q[i];
        hit_map = 1'b1;
      end
      if (paddr == 12'(ICU_DATA0_OFS + 12'(i) * ICU_CTRL_STRIDE)) begin
        rd_mux  = {{(32-TW){1'b0}}, rdat[i]};
        hit_map = 1'b1;
      end
      if (paddr == ICU_FILL_OFS) begin
        rd_mux[8*i +: 8] = {{(8-CW){1'b0}}, cnt[i]};
        hit_map = 1'b1;
      end
    end
    if (paddr == ICU_STAT_OFS) begin
      rd_mux  = {{(32-2*NCH){1'b0}}, stat_q};
      hit_map = 1'b1;
    end
    if (paddr == ICU_MASK_OFS) begin
      rd_mux  = {{(32-2*NCH){1'b0}}, mask_q};
      hit_map = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      prdata_q  <= (psel && penable && !pwrite && !pready_q) ? rd_mux : 32'h0000_0000;
      pslverr_q <= psel && penable && !pready_q && !hit_map;
    end
  end

  assign pready    = pready_q;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q;
  assign irq       = irq_q;
  assign wake_req  = wake_q;
  assign dma_req   = dma_q;
  assign ext_event = ext_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_cap0;
    clk_en && cap[0];
  endsequence

  sequence s_pop0;
    clk_en && pop[0] && !cap[0] && cnt[0] != '0;
  endsequence

  sequence s_full0;
    clk_en && cap[0] && !pop[0] && cnt[0] == CW'(ICU_DEPTH);
  endsequence

  AST_IRQ_FOLLOWS: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && |(stat_q & mask_q) |=> irq_q)
    else $error("irq missing");
  AST_IRQ_QUIET: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && !(|(stat_q & mask_q)) |=> !irq_q)
    else $error("irq without cause");
  AST_DMA_HIGH: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cap0 ##0 ctrl_q[0][ICU_DMA_BIT] |=> dma_q[0])
    else $error("dma missing");
  AST_DMA_IDLE: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && !cap[0] |=> !dma_q[0])
    else $error("dma without capture");
  AST_THR_STICKY: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cap0 ##0 thr_hit[0] |=> stat_q[0])
    else $error("status not set");
  AST_THR_ONE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cap0 ##0 ctrl_q[0][ICU_THR_LSB +: 2] == 2'h0 |=> stat_q[0])
    else $error("one-entry threshold missed");
  AST_EXT_EDGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && edg[0] |=> ext_q[0])
    else $error("event strobe missing");
  AST_EXT_QUIET: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && !edg[0] |=> !ext_q[0])
    else $error("event strobe without edge");
  AST_WAKE: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && cpu_low_power && ctrl_q[1][ICU_WAKE_BIT] && cap[1] |=> wake_q)
    else $error("wake missing");
  AST_WAKE_AWAKE: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && !cpu_low_power |=> !wake_q)
    else $error("wake while running");
  AST_PUSH_COUNT: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && cap[0] && !pop[0] && cnt[0] < CW'(ICU_DEPTH) |=> cnt[0] == $past(cnt[0]) + 1'b1)
    else $error("buffer count wrong");
  AST_POP_COUNT: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_pop0 |=> cnt[0] == $past(cnt[0]) - 1'b1)
    else $error("buffer count after read wrong");
  AST_FULL_DROP: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_full0 |=> cnt[0] == CW'(ICU_DEPTH) && ovf[0])
    else $error("full buffer took a capture");
  AST_OVF_STATUS: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && ovf[0] |=> stat_q[ICU_OVF_LSB])
    else $error("overflow status not set");
  AST_PREADY_ONE: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready_q |=> !pready_q)
    else $error("pready stuck");
endmodule
`default_nettype wire

// ===== dv/icu_pin_src.sv
// icu_pin_src: far-side model, an external signal source on the four capture pins
// assumes one caller at a time; pins change only just after a rising pclk edge
`timescale 1ns/100ps
`default_nettype none
module icu_pin_src (
  input  wire logic       pclk,
  output var  logic [3:0] pins
);
  initial pins = 4'h0;
  // spacing of six cycles keeps one edge at a time in the sync and edge stages
  task automatic drive(input int ch, input logic lvl);
    @(posedge pclk);
    pins[ch] <= lvl;
    repeat (6) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// testbench: self-checking bench for the input capture unit, registers over APB
// assumes icu_pin_src on the pins; a small model here predicts every read
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import icu_pkg::*;
  typedef struct {string nm; logic [32:0] exp; logic [32:0] msk;} icu_note_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        cpu_low_power = 1'b0;
  logic [15:0] ta = 16'h0000, tb = 16'h0000;
  logic        pready, pslverr, irq, wake_req;
  logic [31:0] prdata;
  logic [1:0]  dma_req;
  logic [3:0]  pins, ext_event;
  logic [3:0]  tsel_m = 4'h0, wake_m = 4'h0, dma_m = 4'h0, lvl_m = 4'h0;
  logic [7:0]  stat_m = 8'h00, mask_m = 8'h00;
  icu_mode_t   mode_m [4];
  logic [15:0] mq [4][$];
  icu_note_t   nq [$];
  icu_note_t   note;
  int          thr_m [4], pre [4], ext_cnt [4], ext_exp [4], dma_cnt [2], dma_exp [2];
  int          wake_cnt, wake_exp, failures, cmp_count;
  integer      seed = 73;

  always #5 pclk = ~pclk;

  icu_top uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .capture_input_pin(pins),
    .time_base_a(ta), .time_base_b(tb), .cpu_low_power(cpu_low_power), .irq(irq),
    .wake_req(wake_req), .dma_req(dma_req), .ext_event(ext_event));
  icu_pin_src src (.pclk(pclk), .pins(pins));

  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // APB master: request held until pready is sampled high
  // -----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input string nm, input logic [32:0] exp, input logic [32:0] msk);
    nq.push_back('{nm, exp, msk});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, "write", 33'h0, {1'b1, 32'h0});
  endtask

  task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] e,
                    input logic [31:0] m);
    apb(1'b0, a, 32'h0, nm, {1'b0, e}, {1'b1, m});
  endtask

  // watcher: oldest note against each completed transfer, pulse outputs counted
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (nq.size() > 0) begin
        note = nq.pop_front();
        check(note.nm, {pslverr, prdata} & note.msk, note.exp & note.msk);
      end else begin
        failures++;
      end
    end
    for (int i = 0; i < 4; i++) if (ext_event[i] === 1'b1) ext_cnt[i]++;
    for (int i = 0; i < 2; i++) if (dma_req[i] === 1'b1) dma_cnt[i]++;
    if (wake_req === 1'b1) wake_cnt++;
  end

  // -----------------------------------------------------------------
  // model of channel setup and pin events
  // -----------------------------------------------------------------
  task automatic cfg(input int ch, input icu_mode_t md, input logic ts, input int th,
                     input logic wk, input logic dm);
    logic [31:0] w;
    w = {23'h0, dm, wk, th[1:0], ts, 1'b0, md};
    mode_m[ch] = md;
    tsel_m[ch] = ts;
    thr_m[ch] = th;
    wake_m[ch] = wk;
    dma_m[ch] = dm;
    pre[ch] = 0;
    wr(12'(ICU_CTRL_STRIDE * ch), w);
    rd(12'(ICU_CTRL_STRIDE * ch), "ctrl", w, ch < 2 ? 32'h1FF : 32'h0FF);
  endtask

  task automatic ev(input int ch, input logic lvl);
    logic        q;
    logic [15:0] va, vb;
    q = 1'b0;
    if (lvl != lvl_m[ch]) begin
      ext_exp[ch]++;
      case (mode_m[ch])
        ICU_MODE_FALL: q = !lvl;
        ICU_MODE_RISE: q = lvl;
        ICU_MODE_BOTH: q = 1'b1;
        ICU_MODE_DIV4, ICU_MODE_DIV16: begin
          pre[ch] += lvl;
          q = pre[ch] == (mode_m[ch] == ICU_MODE_DIV4 ? 4 : 16);
          if (q) pre[ch] = 0;
        end
        default: q = 1'b0;
      endcase
    end
    va = 16'($random(seed));
    vb = 16'($random(seed));
    @(posedge pclk);
    ta <= va;
    tb <= vb;
    if (q) begin
      if (mq[ch].size() < 4) mq[ch].push_back(tsel_m[ch] ? vb : va);
      else stat_m[ICU_OVF_LSB + ch] = 1'b1;
      if (mq[ch].size() > thr_m[ch]) stat_m[ch] = 1'b1;
      if (ch < 2 && dma_m[ch]) dma_exp[ch]++;
      if (wake_m[ch] && cpu_low_power) wake_exp++;
    end
    src.drive(ch, lvl);
    lvl_m[ch] = lvl;
  endtask

  task automatic chk();
    rd(ICU_STAT_OFS, "status", {24'h0, stat_m}, 32'hFF);
    rd(ICU_FILL_OFS, "fill", {8'(mq[3].size()), 8'(mq[2].size()), 8'(mq[1].size()),
       8'(mq[0].size())}, 32'hFFFF_FFFF);
    #1;
    check("irq", {32'h0, irq}, {32'h0, |(stat_m & mask_m)});
    for (int i = 0; i < 4; i++) check("ext", 33'(ext_cnt[i]), 33'(ext_exp[i]));
    for (int i = 0; i < 2; i++) check("dma", 33'(dma_cnt[i]), 33'(dma_exp[i]));
    check("wake", 33'(wake_cnt), 33'(wake_exp));
  endtask

  task automatic drain();
    for (int i = 0; i < 4; i++) begin
      while (mq[i].size() > 0) rd(ICU_DATA0_OFS + 12'(4 * i), "data",
        {16'h0, mq[i].pop_front()}, 32'hFFFF);
    end
  endtask

  initial begin
    #300000;
    failures++;
    results();
  end

  initial begin
    for (int i = 0; i < 4; i++) mode_m[i] = ICU_MODE_OFF;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(12'(4 * i), "ctrl reset", ICU_CTRL_RST, 32'hFFFF_FFFF);
    rd(ICU_MASK_OFS, "mask reset", ICU_MASK_RST, 32'hFFFF_FFFF);
    chk();
    apb(1'b0, 12'h02C, 32'h0, "unmapped rd", {1'b1, 32'h0}, {33{1'b1}});
    apb(1'b1, 12'h030, 32'hFFFF_FFFF, "unmapped wr", {1'b1, 32'h0}, {1'b1, 32'h0});
    mask_m = 8'hFF;
    wr(ICU_MASK_OFS, 32'hFF);
    // every threshold code once; ch2 asks for a trigger it must never give
    cfg(0, ICU_MODE_FALL, 1'b0, 0, 1'b0, 1'b1);
    cfg(1, ICU_MODE_RISE, 1'b1, 1, 1'b0, 1'b0);
    cfg(2, ICU_MODE_BOTH, 1'b0, 2, 1'b0, 1'b1);
    cfg(3, ICU_MODE_DIV4, 1'b1, 3, 1'b0, 1'b0);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < (c == 3 ? 5 : 3); k++) begin
        ev(c, 1'b1);
        ev(c, 1'b0);
      end
    end
    chk();
    drain();
    chk();
    stat_m = 8'h00;
    wr(ICU_STAT_OFS, 32'hFF);
    chk();
    cfg(0, ICU_MODE_DIV16, 1'b0, 0, 1'b0, 1'b1);
    cfg(1, ICU_MODE_RISE, 1'b0, 0, 1'b1, 1'b1);
    cfg(2, ICU_MODE_OFF, 1'b0, 0, 1'b0, 1'b0);
    mask_m = 8'h02;
    wr(ICU_MASK_OFS, 32'h02);
    for (int k = 0; k < 16; k++) begin
      ev(0, 1'b1);
      ev(0, 1'b0);
    end
    @(posedge pclk);
    cpu_low_power <= 1'b1;
    ev(1, 1'b1);
    cpu_low_power <= 1'b0;
    ev(1, 1'b0);
    ev(2, 1'b1);
    ev(2, 1'b0);
    chk();
    drain();
    chk();
    results();
  end
endmodule
`default_nettype wire
